/* File: hw/mfr_cfg_pkg.sv */
package mfr_cfg_pkg;
  localparam logic [7:0] CMD_SPECIAL   = 8'hE0;
  localparam logic [7:0] CMD_TEMP_OFS  = 8'hE1;
  localparam logic [7:0] CMD_RTEMP_CAL = 8'hE2;
  localparam logic [7:0] CMD_REMOTE    = 8'hE3;
  localparam logic [7:0] CMD_FFWD      = 8'hE6;
  localparam logic [7:0] CMD_TCOEFF    = 8'hE7;
  // Field positions
  localparam int SO_REQ_PEC = 7;
  localparam int SO_RATIO    = 6;
  localparam int SO_DROOP    = 5;
  localparam int SO_ART      = 3;
  localparam int SO_BUSV     = 2;
  localparam int PIN_COMBINE = 4;
  localparam int PIN_ENABLE  = 2;
  localparam int PIN_POL     = 1;
  localparam int PIN_QUICK   = 0;
  localparam int FFWD_EN     = 0;
  // Writable masks, reserved bits read zero
  localparam logic [7:0]  SO_MASK   = 8'hEC;
  localparam logic [7:0]  PIN_MASK  = 8'h17;
  localparam logic [31:0] FFWD_MASK = 32'hFFFFFF01;
  // Reset values
  localparam logic [7:0]  SO_RST     = 8'h00;
  localparam logic [15:0] TOFS_RST   = 16'h0000;
  localparam logic [31:0] RTCAL_RST  = 32'h00000000;
  localparam logic [7:0]  PIN_RST    = 8'h00;
  localparam logic [31:0] FFWD_RST   = 32'h00000000;
  localparam logic [47:0] TCOEFF_RST = 48'h000000000000;
  // Control interrupt period
  localparam int CLK_MHZ     = 100;
  localparam int CTRL_INT_US = 27;
  localparam int CTRL_INT_CYC = CTRL_INT_US * CLK_MHZ;
  localparam logic [2:0] DAC_STEP_SLOW = 3'h1;
  localparam logic [2:0] DAC_STEP_FAST = 3'h3;

  // Data bytes each command carries; zero for unmapped codes
  function automatic logic [3:0] cmd_bytes(input logic [7:0] code);
    case (code)
      CMD_SPECIAL:   cmd_bytes = 4'h1;
      CMD_TEMP_OFS:  cmd_bytes = 4'h2;
      CMD_RTEMP_CAL: cmd_bytes = 4'h4;
      CMD_REMOTE:    cmd_bytes = 4'h1;
      CMD_FFWD:      cmd_bytes = 4'h4;
      CMD_TCOEFF:    cmd_bytes = 4'h6;
      default:       cmd_bytes = 4'h0;
    endcase
  endfunction
endpackage

/* File: hw/mfr_cfg_regs.sv */
module mfr_cfg_regs (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        data_valid,
  input  wire logic [7:0]  data_byte,
  input  wire logic        stop_valid,
  input  wire logic        pec_present,
  input  wire logic        pec_good,
  input  wire logic [7:0]  rd_code,
  input  wire logic [2:0]  rd_index,
  input  wire logic        remote_onoff_input,
  input  wire logic        ctrl_pin,
  input  wire logic        operation_on,
  input  wire logic [15:0] vin_level,
  input  wire logic [15:0] vin_uv_warn_limit,
  input  wire logic [7:0]  vout_disturbance,
  input  wire logic [7:0]  vin_variation,
  input  wire logic        switch_period_tick,
  input  wire logic [7:0]  reference_dac_error,
  input  wire logic [7:0]  temperature_c,
  input  wire logic [15:0] int_temp_raw,
  input  wire logic [15:0] remote_sensor_volt,
  output logic [7:0]  rd_data_ff,
  output logic        rd_hit_ff,
  output logic        wr_done_ff,
  output logic        wr_reject_ff,
  output logic        dynamic_bus_voltage_ff,
  output logic        adaptive_ramp_load_comp_ff,
  output logic        droop_slope_select_ff,
  output logic        hybrid_ratio_regulation_ff,
  output logic        ratio_track_ff,
  output logic        unit_on_ff,
  output logic        soft_stop_ff,
  output logic        quick_off_ff,
  output logic        duty_halve_ff,
  output logic        vff_armed_ff,
  output logic        dac_step_valid_ff,
  output logic [2:0]  dac_step_ff,
  output logic [7:0]  iout_comp_factor_ff,
  output logic [1:0]  iout_comp_sel_ff,
  output logic [15:0] copper_coeff_ff,
  output logic [15:0] int_temp_report_ff,
  output logic [31:0] remote_temp_ff
);
  import mfr_cfg_pkg::*;

  logic [7:0]  special_option_enables_ff;
  logic [15:0] internal_temp_offset_ff;
  logic [31:0] remote_temp_calibration_ff;
  logic [7:0]  remote_onoff_pin_config_ff;
  logic [31:0] feed_forward_params_ff;
  logic [47:0] current_sense_temp_coeff_ff;
  logic [47:0] stage_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  code_ff;
  logic        active_ff;
  logic        pec_ok;
  logic        commit;
  logic [1:0]  pin_sync_ff;
  logic [1:0]  ctrl_sync_ff;
  logic        pin_asserted;
  logic        nxt_on;
  logic [11:0] int_cnt_ff;
  logic [47:0] rd_word;

  // Write transaction staging; bytes arrive low byte first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage_ff  <= 48'h000000000000;
      cnt_ff    <= 4'h0;
      code_ff   <= 8'h00;
      active_ff <= 1'b0;
    end else if (cmd_valid) begin
      stage_ff  <= 48'h000000000000;
      cnt_ff    <= 4'h0;
      code_ff   <= cmd_code;
      active_ff <= 1'b1;
    end else if (stop_valid) begin
      active_ff <= 1'b0;
    end else if (data_valid && active_ff && cnt_ff < 4'h7) begin
      if (cnt_ff < 4'h6) begin
        stage_ff[cnt_ff[2:0]*8 +: 8] <= data_byte;
      end
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // A bad PEC always voids a write; a missing one only when mandatory
  assign pec_ok = pec_present ? pec_good : !special_option_enables_ff[SO_REQ_PEC];
  assign commit = stop_valid && active_ff && pec_ok && (cmd_bytes(code_ff) != 4'h0)
                  && (cnt_ff == cmd_bytes(code_ff));

  // Write status pulses
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_done_ff   <= 1'b0;
      wr_reject_ff <= 1'b0;
    end else begin
      wr_done_ff   <= commit;
      wr_reject_ff <= stop_valid && active_ff && !commit;
    end
  end

  // Register bank update
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      special_option_enables_ff   <= SO_RST;
      internal_temp_offset_ff     <= TOFS_RST;
      remote_temp_calibration_ff  <= RTCAL_RST;
      remote_onoff_pin_config_ff  <= PIN_RST;
      feed_forward_params_ff      <= FFWD_RST;
      current_sense_temp_coeff_ff <= TCOEFF_RST;
    end else if (commit) begin
      case (code_ff)
        CMD_SPECIAL:   special_option_enables_ff   <= stage_ff[7:0] & SO_MASK;
        CMD_TEMP_OFS:  internal_temp_offset_ff     <= stage_ff[15:0];
        CMD_RTEMP_CAL: remote_temp_calibration_ff  <= stage_ff[31:0];
        CMD_REMOTE:    remote_onoff_pin_config_ff  <= stage_ff[7:0] & PIN_MASK;
        CMD_FFWD:      feed_forward_params_ff      <= stage_ff[31:0] & FFWD_MASK;
        CMD_TCOEFF:    current_sense_temp_coeff_ff <= stage_ff[47:0];
        default:       special_option_enables_ff   <= special_option_enables_ff;
      endcase
    end
  end

  // Read mux, byte selected by index
  always_comb begin
    case (rd_code)
      CMD_SPECIAL:   rd_word = {40'h0000000000, special_option_enables_ff};
      CMD_TEMP_OFS:  rd_word = {32'h00000000, internal_temp_offset_ff};
      CMD_RTEMP_CAL: rd_word = {16'h0000, remote_temp_calibration_ff};
      CMD_REMOTE:    rd_word = {40'h0000000000, remote_onoff_pin_config_ff};
      CMD_FFWD:      rd_word = {16'h0000, feed_forward_params_ff};
      CMD_TCOEFF:    rd_word = current_sense_temp_coeff_ff;
      default:       rd_word = 48'h000000000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= 8'h00;
      rd_hit_ff  <= 1'b0;
    end else begin
      rd_data_ff <= (rd_index < 3'h6) ? rd_word[rd_index*8 +: 8] : 8'h00;
      rd_hit_ff  <= (cmd_bytes(rd_code) != 4'h0) && ({1'b0, rd_index} < cmd_bytes(rd_code));
    end
  end

  // Option enables to the power stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dynamic_bus_voltage_ff     <= 1'b0;
      adaptive_ramp_load_comp_ff <= 1'b0;
      droop_slope_select_ff      <= 1'b0;
      hybrid_ratio_regulation_ff <= 1'b0;
      ratio_track_ff             <= 1'b0;
    end else begin
      dynamic_bus_voltage_ff     <= special_option_enables_ff[SO_BUSV];
      adaptive_ramp_load_comp_ff <= special_option_enables_ff[SO_ART];
      droop_slope_select_ff      <= special_option_enables_ff[SO_DROOP];
      hybrid_ratio_regulation_ff <= special_option_enables_ff[SO_RATIO];
      ratio_track_ff <= special_option_enables_ff[SO_RATIO] && (vin_level < vin_uv_warn_limit);
    end
  end

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync_ff  <= 2'h0;
      ctrl_sync_ff <= 2'h0;
    end else begin
      pin_sync_ff  <= {pin_sync_ff[0], remote_onoff_input};
      ctrl_sync_ff <= {ctrl_sync_ff[0], ctrl_pin};
    end
  end

  // On/off combination; a disabled pin drops out of the equation
  assign pin_asserted = pin_sync_ff[1] ^ remote_onoff_pin_config_ff[PIN_POL];
  always_comb begin
    if (!remote_onoff_pin_config_ff[PIN_ENABLE]) begin
      nxt_on = operation_on && ctrl_sync_ff[1];
    end else if (remote_onoff_pin_config_ff[PIN_COMBINE]) begin
      nxt_on = pin_asserted && operation_on && ctrl_sync_ff[1];
    end else begin
      nxt_on = pin_asserted || (operation_on && ctrl_sync_ff[1]);
    end
  end

  // Turn-off style latched at the falling edge of the on state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      unit_on_ff   <= 1'b0;
      soft_stop_ff <= 1'b0;
      quick_off_ff <= 1'b0;
    end else begin
      unit_on_ff <= nxt_on;
      if (nxt_on) begin
        soft_stop_ff <= 1'b0;
        quick_off_ff <= 1'b0;
      end else if (unit_on_ff) begin
        soft_stop_ff <= !remote_onoff_pin_config_ff[PIN_QUICK];
        quick_off_ff <= remote_onoff_pin_config_ff[PIN_QUICK];
      end
    end
  end

  // Feed-forward extra compensation, re-armed once input settles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      duty_halve_ff <= 1'b0;
      vff_armed_ff  <= 1'b0;
    end else if (!feed_forward_params_ff[FFWD_EN]) begin
      duty_halve_ff <= 1'b0;
      vff_armed_ff  <= 1'b0;
    end else if (switch_period_tick) begin
      duty_halve_ff <= vff_armed_ff && (vout_disturbance > feed_forward_params_ff[31:24]);
      if (vff_armed_ff && (vout_disturbance > feed_forward_params_ff[31:24])) begin
        vff_armed_ff <= 1'b0;
      end else if (vin_variation <= feed_forward_params_ff[23:16]) begin
        vff_armed_ff <= 1'b1;
      end
    end
  end

  // Control interrupt timer and reference DAC step size
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      int_cnt_ff        <= 12'h000;
      dac_step_valid_ff <= 1'b0;
      dac_step_ff       <= 3'h0;
    end else begin
      dac_step_valid_ff <= 1'b0;
      if (int_cnt_ff == 12'(CTRL_INT_CYC - 1)) begin
        int_cnt_ff        <= 12'h000;
        dac_step_valid_ff <= 1'b1;
        dac_step_ff <= (reference_dac_error >= feed_forward_params_ff[15:8]) ?
                       DAC_STEP_FAST : DAC_STEP_SLOW;
      end else begin
        int_cnt_ff <= int_cnt_ff + 12'h001;
      end
    end
  end

  // Current sense temperature compensation and temperature reporting
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      iout_comp_factor_ff <= 8'h00;
      iout_comp_sel_ff    <= 2'h0;
      copper_coeff_ff     <= 16'h0000;
      int_temp_report_ff  <= 16'h0000;
      remote_temp_ff      <= 32'h00000000;
    end else begin
      if (temperature_c > current_sense_temp_coeff_ff[39:32]) begin
        iout_comp_factor_ff <= current_sense_temp_coeff_ff[47:40];
        iout_comp_sel_ff    <= 2'h2;
      end else if (temperature_c > current_sense_temp_coeff_ff[23:16]) begin
        iout_comp_factor_ff <= current_sense_temp_coeff_ff[31:24];
        iout_comp_sel_ff    <= 2'h1;
      end else begin
        iout_comp_factor_ff <= 8'h00;
        iout_comp_sel_ff    <= 2'h0;
      end
      copper_coeff_ff    <= current_sense_temp_coeff_ff[15:0];
      int_temp_report_ff <= int_temp_raw + internal_temp_offset_ff;
      remote_temp_ff     <= 32'(remote_temp_calibration_ff[31:16] * remote_sensor_volt)
                            + {16'h0000, remote_temp_calibration_ff[15:0]};
    end
  end

  // Checks
  property p_pec_required;
    @(posedge sys_clk) disable iff (!rstn)
    (stop_valid && !pec_present && special_option_enables_ff[SO_REQ_PEC]) |=> !wr_done_ff;
  endproperty
  a_pec_required: assert property (p_pec_required) else $error("write taken without PEC");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!rstn)
    special_option_enables_ff[1:0] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_ratio;
    @(posedge sys_clk) disable iff (!rstn)
    ratio_track_ff |-> $past(special_option_enables_ff[SO_RATIO]);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio track without enable");

  property p_dbv;
    @(posedge sys_clk) disable iff (!rstn)
    $rose(special_option_enables_ff[SO_BUSV]) |=> dynamic_bus_voltage_ff;
  endproperty
  a_dbv: assert property (p_dbv) else $error("bus voltage enable lagging");

  property p_quick;
    @(posedge sys_clk) disable iff (!rstn)
    (unit_on_ff && !nxt_on && remote_onoff_pin_config_ff[PIN_QUICK]) |=> quick_off_ff && !soft_stop_ff;
  endproperty
  a_quick: assert property (p_quick) else $error("quick off not taken");

  property p_pin_ignored;
    @(posedge sys_clk) disable iff (!rstn)
    !remote_onoff_pin_config_ff[PIN_ENABLE] |=> (unit_on_ff == $past(operation_on && ctrl_sync_ff[1]));
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("disabled pin acted");

  property p_dac_fast;
    @(posedge sys_clk) disable iff (!rstn)
    dac_step_valid_ff |-> (dac_step_ff == DAC_STEP_FAST || dac_step_ff == DAC_STEP_SLOW) ##1
      !dac_step_valid_ff [*8];
  endproperty
  a_dac_fast: assert property (p_dac_fast) else $error("bad DAC step or spacing");

  property p_vff_off;
    @(posedge sys_clk) disable iff (!rstn)
    !feed_forward_params_ff[FFWD_EN] |=> !duty_halve_ff;
  endproperty
  a_vff_off: assert property (p_vff_off) else $error("halving while disabled");

  property p_halve_one;
    @(posedge sys_clk) disable iff (!rstn)
    (duty_halve_ff && !switch_period_tick) |=> duty_halve_ff == $past(duty_halve_ff) ##0 !vff_armed_ff;
  endproperty
  a_halve_one: assert property (p_halve_one) else $error("halving re-armed early");

  property p_level2;
    @(posedge sys_clk) disable iff (!rstn)
    (temperature_c > current_sense_temp_coeff_ff[39:32]) |=> iout_comp_sel_ff == 2'h2;
  endproperty
  a_level2: assert property (p_level2) else $error("level two factor not applied");

  c_commit: cover property (@(posedge sys_clk) disable iff (!rstn) wr_done_ff);
  c_reject: cover property (@(posedge sys_clk) disable iff (!rstn) wr_reject_ff);
  c_soft:   cover property (@(posedge sys_clk) disable iff (!rstn) $rose(soft_stop_ff));
  c_halve:  cover property (@(posedge sys_clk) disable iff (!rstn) duty_halve_ff);
endmodule // mfr_cfg_regs

/* File: test/pmbus_host_model.sv */
// Management bus host: frames whole writes and supplies the PEC flags
module pmbus_host_model (
  input  wire logic       sys_clk,
  input  wire logic       wr_done_ff,
  input  wire logic       wr_reject_ff,
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  output logic            data_valid,
  output logic [7:0]      data_byte,
  output logic            stop_valid,
  output logic            pec_present,
  output logic            pec_good
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    {cmd_valid, data_valid, stop_valid, pec_present, pec_good} = 5'h00;
    cmd_code = 8'h00;
    data_byte = 8'h00;
  end

  // Command, data low byte first, then stop with PEC status
  task automatic write(input logic [7:0] code, input logic [47:0] val, input int n,
                       input logic pp, input logic pg, output logic [1:0] res);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      cmd_valid  <= 1'b0;
      data_valid <= 1'b1;
      data_byte  <= val[8*i+:8];
    end
    @(posedge sys_clk);
    cmd_valid   <= 1'b0;
    data_valid  <= 1'b0;
    data_byte   <= ~data_byte; // Released data lines do not keep the last byte
    stop_valid  <= 1'b1;
    pec_present <= pp;
    pec_good    <= pg;
    @(posedge sys_clk);
    stop_valid  <= 1'b0;
    pec_present <= ~pp;
    pec_good    <= ~pg;
    #1 res = {wr_done_ff, wr_reject_ff};
  endtask
endmodule // pmbus_host_model

/* File: test/converter_mfr_config_registers_tb.sv */
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module converter_mfr_config_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mfr_cfg_pkg::*;
  logic sys_clk = 0, rstn = 0, remote_onoff_input = 0, ctrl_pin = 0, operation_on = 0;
  logic switch_period_tick = 0;
  logic [7:0] rd_code = 0, vout_disturbance = 0, vin_variation = 0, temperature_c = 0;
  logic [7:0] reference_dac_error = 0;
  logic [2:0] rd_index = 0;
  logic [15:0] vin_level = 0, vin_uv_warn_limit = 0, int_temp_raw = 0, remote_sensor_volt = 0;
  logic cmd_valid, data_valid, stop_valid, pec_present, pec_good, rd_hit_ff, wr_done_ff;
  logic wr_reject_ff, busv, art, droop, ratio_en, ratio_track_ff, unit_on_ff, soft_stop_ff;
  logic quick_off_ff, duty_halve_ff, vff_armed_ff, dac_step_valid_ff;
  logic [7:0] cmd_code, data_byte, rd_data_ff, iout_comp_factor_ff;
  logic [2:0] dac_step_ff;
  logic [1:0] iout_comp_sel_ff;
  logic [15:0] copper_coeff_ff, int_temp_report_ff;
  logic [31:0] remote_temp_ff;
  int n_mismatch = 0, checks = 0;
  logic [7:0] codes [6] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE6, 8'hE7};
  int sz [6] = '{1, 2, 4, 1, 4, 6};
  logic [47:0] masks [6] = '{48'(SO_MASK), 48'h00FFFF, 48'hFFFFFFFF, 48'(PIN_MASK),
                             48'(FFWD_MASK), 48'hFFFFFFFFFFFF};
  logic [11:0] rows [8] = '{12'h007, 12'h00A, 12'h049, 12'h040,
                            12'h14F, 12'h14A, 12'h071, 12'h078};

  mfr_cfg_regs dut_u (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .data_valid(data_valid), .data_byte(data_byte),
    .stop_valid(stop_valid), .pec_present(pec_present), .pec_good(pec_good),
    .rd_code(rd_code), .rd_index(rd_index), .remote_onoff_input(remote_onoff_input),
    .ctrl_pin(ctrl_pin), .operation_on(operation_on), .vin_level(vin_level),
    .vin_uv_warn_limit(vin_uv_warn_limit), .vout_disturbance(vout_disturbance),
    .vin_variation(vin_variation), .switch_period_tick(switch_period_tick),
    .reference_dac_error(reference_dac_error), .temperature_c(temperature_c),
    .int_temp_raw(int_temp_raw), .remote_sensor_volt(remote_sensor_volt),
    .rd_data_ff(rd_data_ff), .rd_hit_ff(rd_hit_ff), .wr_done_ff(wr_done_ff),
    .wr_reject_ff(wr_reject_ff), .dynamic_bus_voltage_ff(busv),
    .adaptive_ramp_load_comp_ff(art), .droop_slope_select_ff(droop),
    .hybrid_ratio_regulation_ff(ratio_en), .ratio_track_ff(ratio_track_ff),
    .unit_on_ff(unit_on_ff), .soft_stop_ff(soft_stop_ff), .quick_off_ff(quick_off_ff),
    .duty_halve_ff(duty_halve_ff), .vff_armed_ff(vff_armed_ff),
    .dac_step_valid_ff(dac_step_valid_ff), .dac_step_ff(dac_step_ff),
    .iout_comp_factor_ff(iout_comp_factor_ff), .iout_comp_sel_ff(iout_comp_sel_ff),
    .copper_coeff_ff(copper_coeff_ff), .int_temp_report_ff(int_temp_report_ff),
    .remote_temp_ff(remote_temp_ff));

  pmbus_host_model host_u (.sys_clk(sys_clk), .wr_done_ff(wr_done_ff),
    .wr_reject_ff(wr_reject_ff), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .data_valid(data_valid), .data_byte(data_byte), .stop_valid(stop_valid),
    .pec_present(pec_present), .pec_good(pec_good));

  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Write and compare the done or reject answer
  task automatic wr(input logic [7:0] c, input logic [47:0] v, input int n,
                    input logic pp, input logic pg, input logic ok);
    logic [1:0] res;
    host_u.write(c, v, n, pp, pg, res);
    `CHK("write answer", (ok ? 2'b10 : 2'b01), res)
  endtask

  // Read every byte of a register, then one past its end
  task automatic chk_reg(input logic [7:0] c, input int n, input logic [47:0] exp);
    logic [47:0] v;
    v = '0;
    for (int i = 0; i <= n; i++) begin
      @(posedge sys_clk);
      rd_code  <= c;
      rd_index <= 3'(i);
      cyc(1);
      `CHK("read hit", (i < n), rd_hit_ff)
      if (i < n) v[8*i+:8] = rd_data_ff;
      else `CHK("read past end", 8'h00, rd_data_ff)
    end
    `CHK("register value", exp, v)
  endtask

  task automatic tick();
    @(posedge sys_clk);
    switch_period_tick <= 1'b1;
    @(posedge sys_clk);
    switch_period_tick <= 1'b0;
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog over roughly five times the expected run
  initial begin
    #300000;
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [7:0] cfg;
    logic pon, s, q;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 6; k++) chk_reg(codes[k], sz[k], 48'h0);
    for (int k = 0; k < 6; k++) begin
      wr(codes[k], '1, sz[k], 1'b1, 1'b1, 1'b1);
      chk_reg(codes[k], sz[k], masks[k]);
    end
    `CHK("dynamic bus", 1'b1, busv)
    `CHK("adaptive ramp", 1'b1, art)
    `CHK("droop select", 1'b1, droop)
    `CHK("ratio enable", 1'b1, ratio_en)
    @(posedge sys_clk);
    vin_level <= 16'h000A;
    vin_uv_warn_limit <= 16'h0014;
    cyc(2);
    `CHK("ratio track low", 1'b1, ratio_track_ff)
    @(posedge sys_clk);
    vin_level <= 16'h001E;
    cyc(2);
    `CHK("ratio track high", 1'b0, ratio_track_ff)
    wr(8'hE1, 48'h1234, 2, 1'b0, 1'b0, 1'b0);
    wr(8'hE1, 48'h1234, 2, 1'b1, 1'b0, 1'b0);
    wr(8'hE1, 48'h1234, 1, 1'b1, 1'b1, 1'b0);
    wr(8'hE4, 48'h12, 1, 1'b1, 1'b1, 1'b0);
    chk_reg(8'hE4, 0, 48'h0);
    chk_reg(8'hE1, 2, 48'hFFFF);
    wr(8'hE0, 48'h0, 1, 1'b1, 1'b1, 1'b1);
    cyc(1);
    `CHK("droop select off", 1'b0, droop)
    wr(8'hE1, 48'h000A, 2, 1'b0, 1'b0, 1'b1);
    wr(8'hE2, 48'h00030005, 4, 1'b0, 1'b0, 1'b1);
    wr(8'hE7, 48'h225011281234, 6, 1'b0, 1'b0, 1'b1);
    @(posedge sys_clk);
    int_temp_raw <= 16'd100;
    remote_sensor_volt <= 16'd10;
    cyc(2);
    `CHK("internal temp", 16'd110, int_temp_report_ff)
    `CHK("remote temp", 32'd35, remote_temp_ff)
    `CHK("copper coeff", 16'h1234, copper_coeff_ff)
    foreach (codes[k]) begin
      @(posedge sys_clk);
      temperature_c <= 8'(39 + k * 14);
      cyc(2);
      `CHK("iout sel", (k < 1 ? 2'd0 : k < 3 ? 2'd1 : 2'd2), iout_comp_sel_ff)
      `CHK("iout factor", (k < 1 ? 8'h00 : k < 3 ? 8'h11 : 8'h22), iout_comp_factor_ff)
    end
    cfg = 8'hFF;
    pon = 1'b0;
    s = 1'b0;
    q = 1'b0;
    foreach (rows[r]) begin
      if (rows[r][11:4] !== cfg) wr(8'hE3, 48'(rows[r][11:4]), 1, 1'b0, 1'b0, 1'b1);
      cfg = rows[r][11:4];
      @(posedge sys_clk);
      {remote_onoff_input, operation_on, ctrl_pin} <= rows[r][3:1];
      cyc(4);
      `CHK("unit on", rows[r][0], unit_on_ff)
      if (rows[r][0]) {s, q} = 2'b00;
      else if (pon) {s, q} = {~cfg[0], cfg[0]};
      pon = rows[r][0];
      `CHK("soft stop", s, soft_stop_ff)
      `CHK("quick off", q, quick_off_ff)
    end
    wr(8'hE6, 48'h40102001, 4, 1'b0, 1'b0, 1'b1);
    @(posedge sys_clk);
    vin_variation <= 8'h05;
    tick();
    `CHK("ff armed", 1'b1, vff_armed_ff)
    @(posedge sys_clk);
    vout_disturbance <= 8'h50;
    tick();
    `CHK("duty halve", 1'b1, duty_halve_ff)
    tick();
    `CHK("duty halve one period", 1'b0, duty_halve_ff)
    wr(8'hE6, 48'h40102000, 4, 1'b0, 1'b0, 1'b1);
    cyc(1);
    `CHK("ff disarmed", 1'b0, vff_armed_ff)
    tick();
    `CHK("duty halve disabled", 1'b0, duty_halve_ff)
    for (int e = 0; e < 2; e++) begin
      @(posedge sys_clk);
      reference_dac_error <= (e == 0) ? 8'h20 : 8'h1F;
      cyc(2);
      for (int w = 0; w < 3000 && dac_step_valid_ff !== 1'b1; w++) cyc(1);
      `CHK("dac step pulse", 1'b1, dac_step_valid_ff)
      `CHK("dac step", (e == 0 ? DAC_STEP_FAST : DAC_STEP_SLOW), dac_step_ff)
      cyc(2);
    end
    // Thresholds put back to their reset values
    wr(8'hE6, 48'h0, 4, 1'b0, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule // converter_mfr_config_registers_tb
